//--- src/chg_sup_pkg.sv
// package of constants and carrier types for the charger supervisor
package chg_sup_pkg;
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned CLK_NS          = 5;
    // interrupt pulse width
    localparam int unsigned IRQ_PULSE_US    = 128;
    localparam int unsigned IRQ_PULSE_CYC   = IRQ_PULSE_US * 1000 / CLK_NS;
    // host watchdog interval
    localparam longint unsigned WDOG_S      = 50;
    localparam longint unsigned WDOG_CYC    = WDOG_S * CLK_HZ;
    // safety timer base tick (one minute) and precharge fraction
    localparam longint unsigned MIN_CYC     = 60 * CLK_HZ;
    localparam int unsigned PRE_DIV         = 10;
    // safety duration select field width
    localparam int unsigned DSEL_W          = 2;
    // warm-zone target drop, floor and target width (mV)
    localparam int unsigned VT_W            = 13;
    localparam logic [12:0] WARM_DROP_MV    = 13'h008C;
    localparam logic [12:0] VT_FLOOR_MV     = 13'h0E10;
    // charge-state and error-code encodings
    localparam logic [1:0] ST_READY         = 2'h0;
    localparam logic [1:0] ST_CHARGE        = 2'h1;
    localparam logic [1:0] ST_DONE          = 2'h2;
    localparam logic [1:0] ST_FAULT         = 2'h3;
    localparam logic [2:0] ERR_NONE         = 3'h0;
    localparam logic [2:0] ERR_SAFETY       = 3'h1;
    localparam logic [2:0] ERR_THERMAL      = 3'h2;
    localparam logic [2:0] ERR_BATTEMP      = 3'h3;

    typedef enum logic [2:0] {
        CH_IDLE, CH_PRE, CH_FAST, CH_DONE, CH_FAULT
    } chg_state_t;

    // thermistor zone comparator results
    typedef struct packed {
        logic ts_off;
        logic cold;
        logic cool;
        logic warm;
        logic hot;
    } ts_zone_t;

    // analog loop and supply comparator flags
    typedef struct packed {
        logic vin_uvlo_ok;
        logic vin_above_bat;
        logic vin_below_ovp;
        logic die_shutdown;
        logic die_below_hys;
        logic loop_cc;
        logic loop_cv;
        logic loop_other;
    } analog_flags_t;
endpackage

//--- src/charger_supervisor_timers.sv
// charger supervisor: safety timer, watchdog, zones, thermal, status pins
// Function
// - safety timer expiry ends charge into fault
// - precharge limited to one tenth duration
// - timer fault gives one 128us interrupt pulse
// - fault clears only on disable or power toggle
// - duration select, change restarts running timer
// - half rate timer outside cc/cv loops
// - 50s watchdog starts after first host access
// - hiz disables watchdog until new access
// - each host access outside hiz reloads watchdog
// - expiry restores defaults except button cfgs
// - hot or cold suspends charge, freezes safety timer
// - cool zone halves fast charge current
// - warm zone drops target 140mV, floor 3.6V
// - thermistor off disables zone reactions
// - thermal shutdown stops charge and outputs
// - shutdown resets safety timer, watchdog runs
// - resume only below limit by hysteresis
// - status valid after good start, no pulses
// - power good low only for valid input
// - remap bit makes power good follow button
// - interrupt low while charging, faults pulse
// - battery only: rails on, pin latches aux on
// - input present: disable pin gates charge
`timescale 1ns/1ps
`default_nettype none
module charger_supervisor_timers
    import chg_sup_pkg::*;
#(
    parameter longint unsigned MIN_CYCLES  = MIN_CYC,
    parameter longint unsigned WDOG_CYCLES = WDOG_CYC,
    parameter int unsigned     PULSE_CYC   = IRQ_PULSE_CYC
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    // supply, loop and thermal comparators
    input  wire analog_flags_t    i_flags,
    input  wire ts_zone_t         i_zone,
    input  wire logic             i_vin_present,
    input  wire logic             i_startup_done,
    input  wire logic             i_startup_fault,
    // charger engine events
    input  wire logic             i_precharge,
    input  wire logic             i_terminated,
    input  wire logic             i_recharge_req,
    // configuration
    input  wire logic [1:0]       i_safety_duration_sel,
    input  wire logic             i_half_rate_timer_en,
    input  wire logic             i_int_enable,
    input  wire logic             i_good_pin_button_remap,
    input  wire logic             i_hiz_mode,
    input  wire logic [VT_W-1:0]  i_battery_regulation_target,
    input  wire logic             i_host_access,
    // pins
    input  wire logic             i_chip_disable_n,
    input  wire logic             i_manual_reset_button,
    input  wire logic             i_aux_output_control_pin,
    input  wire logic             i_aux_enabled,
    // charge and rail controls
    output logic                  o_charge_en,
    output logic                  o_half_current,
    output logic [VT_W-1:0]       o_reg_target,
    output logic                  o_middle_power_node_en,
    output logic                  o_buck_output_rail_en,
    output logic                  o_aux_switch_output_en,
    output logic                  o_regs_to_default,
    // status fields
    output logic [1:0]            o_charge_state,
    output logic [2:0]            o_error_code,
    // open-drain pins, enable high pulls low
    output logic                  o_int_o,
    output logic                  o_int_oe,
    output logic                  o_power_good_n_o,
    output logic                  o_power_good_n_oe
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        chg_state_t    st;
        logic [39:0]   sub;
        logic [15:0]   mins;
        logic          half_ph;
        logic [1:0]    dsel;
        logic [39:0]   wd;
        logic          wd_run;
        logic [15:0]   pulse;
        logic          tshut;
        logic          aux_on;
        logic          cd_prev;
        logic          vin_prev;
        logic          wd_fire;
        logic [2:0]    err;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // duration in minutes per select code
    function automatic logic [15:0] dur_min(input logic [1:0] sel);
        case (sel)
            2'h0:    dur_min = 16'h001E;
            2'h1:    dur_min = 16'h00B4;
            2'h2:    dur_min = 16'h0168;
            default: dur_min = 16'hFFFF;
        endcase
    endfunction

    logic zone_act;
    logic susp;
    logic run_ok;
    logic limit_hit;
    logic [15:0] lim;
    logic [VT_W-1:0] warm_t;

    // zone qualifiers and limits
    always_comb begin
        zone_act  = !i_zone.ts_off;
        susp      = zone_act && (i_zone.hot || i_zone.cold);
        run_ok    = i_chip_disable_n == 1'b0 && i_vin_present;
        lim       = (s_r.st == CH_PRE) ?
                    16'(dur_min(s_r.dsel) / 16'(PRE_DIV)) :
                    dur_min(s_r.dsel);
        limit_hit = (s_r.mins >= lim) && (s_r.dsel != 2'h3);
        warm_t    = (i_battery_regulation_target >
                     VT_FLOOR_MV + WARM_DROP_MV) ?
                    i_battery_regulation_target - WARM_DROP_MV :
                    VT_FLOOR_MV;
    end

    // next-state logic
    always_comb begin
        s_nxt          = s_r;
        s_nxt.cd_prev  = i_chip_disable_n;
        s_nxt.vin_prev = i_vin_present;
        s_nxt.wd_fire  = 1'b0;
        // thermal shutdown with hysteresis
        if (i_flags.die_shutdown) begin
            s_nxt.tshut = 1'b1;
        end else if (i_flags.die_below_hys) begin
            s_nxt.tshut = 1'b0;
        end
        // aux output memory and pin control
        if (s_r.tshut) begin
            s_nxt.aux_on = 1'b0;
        end else if (!i_vin_present && !i_chip_disable_n) begin
            s_nxt.aux_on = s_r.aux_on | i_aux_output_control_pin;
        end else begin
            s_nxt.aux_on = i_aux_enabled | i_aux_output_control_pin;
        end
        // safety timer tick, half rate outside cc/cv
        if (s_r.st == CH_PRE || s_r.st == CH_FAST) begin
            if (!susp) begin
                if (s_r.sub >= 40'(MIN_CYCLES - 1)) begin
                    s_nxt.sub = '0;
                    if (i_half_rate_timer_en && i_flags.loop_other &&
                        !i_flags.loop_cc && !i_flags.loop_cv) begin
                        s_nxt.half_ph = !s_r.half_ph;
                        if (s_r.half_ph) s_nxt.mins = s_r.mins + 16'h0001;
                    end else begin
                        s_nxt.mins = s_r.mins + 16'h0001;
                    end
                end else begin
                    s_nxt.sub = s_r.sub + 40'h1;
                end
            end
        end
        // charge sequencing
        case (s_r.st)
            CH_IDLE: begin
                if (run_ok && !s_r.tshut && i_startup_done) begin
                    s_nxt.st = i_precharge ? CH_PRE : CH_FAST;
                end
            end
            CH_PRE, CH_FAST: begin
                if (s_r.st == CH_PRE && !i_precharge) s_nxt.st = CH_FAST;
                if (i_terminated) begin
                    s_nxt.st = CH_DONE;
                end else if (limit_hit) begin
                    s_nxt.st    = CH_FAULT;
                    s_nxt.err   = ERR_SAFETY;
                    s_nxt.pulse = 16'(PULSE_CYC);
                end
            end
            CH_DONE: begin
                if (i_recharge_req) s_nxt.st = CH_IDLE;
            end
            CH_FAULT: begin
                // only a disable or power toggle clears it
                if ((i_chip_disable_n && !s_r.cd_prev) ||
                    (i_vin_present && !s_r.vin_prev)) begin
                    s_nxt.st  = CH_IDLE;
                    s_nxt.err = ERR_NONE;
                end
            end
            default: s_nxt.st = CH_IDLE;
        endcase
        if (s_r.st != CH_FAULT && (!run_ok || s_r.tshut)) begin
            s_nxt.st = CH_IDLE;
        end
        // timer cleared off-charge, on duration change, shutdown
        if (s_nxt.st == CH_IDLE || s_nxt.st == CH_DONE || s_r.tshut ||
            i_safety_duration_sel != s_r.dsel ||
            (s_r.st == CH_PRE && s_nxt.st == CH_FAST)) begin
            s_nxt.sub     = '0;
            s_nxt.mins    = '0;
            s_nxt.half_ph = 1'b0;
        end
        s_nxt.dsel = i_safety_duration_sel;
        // thermal fault pulse on shutdown entry
        if (i_flags.die_shutdown && !s_r.tshut && s_r.pulse == 16'h0000) begin
            s_nxt.pulse = 16'(PULSE_CYC);
            s_nxt.err   = ERR_THERMAL;
        end else if (s_r.pulse != 16'h0000 && s_nxt.pulse == s_r.pulse) begin
            s_nxt.pulse = s_r.pulse - 16'h0001;
        end
        if (!i_startup_done || i_startup_fault) s_nxt.pulse = '0;
        // watchdog, keeps counting through thermal shutdown
        if (i_hiz_mode) begin
            s_nxt.wd_run = 1'b0;
        end else if (i_host_access) begin
            s_nxt.wd_run = 1'b1;
            s_nxt.wd     = 40'(WDOG_CYCLES - 1);
        end else if (s_r.wd_run) begin
            if (s_r.wd == '0) begin
                s_nxt.wd_run  = 1'b0;
                s_nxt.wd_fire = 1'b1;
            end else begin
                s_nxt.wd = s_r.wd - 40'h1;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r         <= '0;
            s_r.st      <= CH_IDLE;
            s_r.cd_prev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    always_comb begin
        o_charge_en      = s_r.st == CH_PRE || s_r.st == CH_FAST;
        o_charge_en      = o_charge_en && !susp && !s_r.tshut;
        o_half_current   = zone_act && i_zone.cool;
        o_reg_target     = (zone_act && i_zone.warm) ? warm_t :
                           i_battery_regulation_target;
        o_middle_power_node_en = !s_r.tshut;
        o_buck_output_rail_en  = !s_r.tshut;
        o_aux_switch_output_en = s_r.aux_on && !s_r.tshut;
        o_regs_to_default      = s_r.wd_fire;
        case (s_r.st)
            CH_PRE, CH_FAST: o_charge_state = ST_CHARGE;
            CH_DONE:         o_charge_state = ST_DONE;
            CH_FAULT:        o_charge_state = ST_FAULT;
            default:         o_charge_state = ST_READY;
        endcase
        o_error_code = s_r.err;
        o_int_o      = 1'b0;
        o_int_oe     = i_startup_done && !i_startup_fault &&
                       ((i_int_enable && o_charge_state == ST_CHARGE) ||
                        s_r.pulse != 16'h0000);
        o_power_good_n_o  = 1'b0;
        o_power_good_n_oe = i_good_pin_button_remap ?
                            !i_manual_reset_button :
                            (i_startup_done && i_flags.vin_uvlo_ok &&
                             i_flags.vin_above_bat &&
                             i_flags.vin_below_ovp);
    end

    // ********************************
    // checks
    // ********************************
    chk_pulse_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_r.pulse == 16'(PULSE_CYC) |-> ##1 s_r.pulse != 16'(PULSE_CYC)
                   || !i_startup_done)
        else $error("pulse counter stuck");
    chk_fault_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_r.st == CH_FAULT && i_chip_disable_n == s_r.cd_prev
        && (i_vin_present == s_r.vin_prev || !i_vin_present)
        |=> s_r.st == CH_FAULT)
        else $error("fault cleared without toggle");
    chk_wd_reload: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_host_access && !i_hiz_mode |=> s_r.wd_run
        && s_r.wd == 40'(WDOG_CYCLES - 1))
        else $error("watchdog not reloaded");
    chk_hiz_stop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_hiz_mode |=> !s_r.wd_run)
        else $error("watchdog runs in hiz");
    chk_tshut_rails: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_r.tshut |-> !o_charge_en && !o_buck_output_rail_en)
        else $error("rails on in shutdown");
    chk_tshut_timer: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_r.tshut |=> s_r.mins == '0 && s_r.sub == '0)
        else $error("safety timer runs in shutdown");
    chk_susp_freeze: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        susp && !s_r.tshut && $stable(i_safety_duration_sel)
        && s_nxt.st == s_r.st |=> $stable(s_r.sub))
        else $error("timer moved while suspended");
    chk_dsel_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        i_safety_duration_sel != s_r.dsel |=> s_r.mins == '0)
        else $error("duration change did not restart");
    chk_warm_floor: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        zone_act && i_zone.warm |-> o_reg_target >= VT_FLOOR_MV)
        else $error("warm target under floor");
endmodule
`default_nettype wire

//--- test/host_model.sv
// host model: pulls up the interrupt line, counts pulses, makes accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic i_clk,
    input  wire logic i_int_oe,
    output logic      o_host_access,
    output int        o_pulses,
    output int        o_width
);
    // pull-up resistor on the open-drain interrupt line
    wire logic int_n = ~i_int_oe;
    int        run;

    initial begin
        o_host_access = 1'b0;
        o_pulses = 0;
        o_width = 0;
        run = 0;
    end

    // measure each low period of the interrupt line in clock cycles
    always @(posedge i_clk) begin
        if (!int_n) begin
            run <= run + 1;
        end else if (run != 0) begin
            o_pulses <= o_pulses + 1;
            o_width <= run;
            run <= 0;
        end
    end

    // one bus transaction shows as a single-cycle pulse
    task automatic access();
        @(negedge i_clk);
        o_host_access = 1'b1;
        @(negedge i_clk);
        o_host_access = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/charger_supervisor_timers_tb.sv
// testbench for the charger supervisor timers
`timescale 1ns/1ps
`default_nettype none
module charger_supervisor_timers_tb;
    import chg_sup_pkg::*;
    localparam int PC = 8;
    logic          clk, arst_n, vin, sdone, sfault, pre, term, rech;
    logic [1:0]    dsel;
    logic          half_en, int_en, remap, hiz, cd_n, btn, auxp, aux_en;
    logic [12:0]   vt;
    analog_flags_t flags;
    ts_zone_t      zone;
    logic          acc, chg_en, half_i, mid_en, buck_en, aux_o, regs_def;
    logic [12:0]   vt_o;
    logic [1:0]    st;
    logic [2:0]    err;
    logic          int_oe, pg_oe;
    int            pulses, width, fails, samples_checked, wd_hits, n;

    charger_supervisor_timers #(.MIN_CYCLES(10), .WDOG_CYCLES(50),
        .PULSE_CYC(PC)) i_dut (
        .i_clk(clk), .i_arst_n(arst_n), .i_flags(flags), .i_zone(zone),
        .i_vin_present(vin), .i_startup_done(sdone),
        .i_startup_fault(sfault), .i_precharge(pre), .i_terminated(term),
        .i_recharge_req(rech), .i_safety_duration_sel(dsel),
        .i_half_rate_timer_en(half_en), .i_int_enable(int_en),
        .i_good_pin_button_remap(remap), .i_hiz_mode(hiz),
        .i_battery_regulation_target(vt), .i_host_access(acc),
        .i_chip_disable_n(cd_n), .i_manual_reset_button(btn),
        .i_aux_output_control_pin(auxp), .i_aux_enabled(aux_en),
        .o_charge_en(chg_en), .o_half_current(half_i), .o_reg_target(vt_o),
        .o_middle_power_node_en(mid_en), .o_buck_output_rail_en(buck_en),
        .o_aux_switch_output_en(aux_o), .o_regs_to_default(regs_def),
        .o_charge_state(st), .o_error_code(err), .o_int_o(),
        .o_int_oe(int_oe), .o_power_good_n_o(), .o_power_good_n_oe(pg_oe));

    host_model u_host (.i_clk(clk), .i_int_oe(int_oe), .o_host_access(acc),
        .o_pulses(pulses), .o_width(width));

    // clock and watchdog-expiry counter
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (regs_def === 1'b1) wd_hits <= wd_hits + 1;

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic wait_st(logic [1:0] s, int lim);
        n = 0;
        while (st !== s && n < lim) begin
            tick(1);
            n++;
        end
        check("reach state", st, s);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // timer fault after lim cycles of charging, one pulse, latched
    task automatic t_fault(int lim);
        int p0;
        p0 = pulses;
        cd_n = 1'b1;
        tick(3);
        check("chg off", chg_en, 0);
        cd_n = 1'b0;
        wait_st(ST_CHARGE, 10);
        wait_st(ST_FAULT, lim + 20);
        check("fault time", n >= lim && n <= lim + 2, 1);
        check("err", err, ERR_SAFETY);
        check("chg en", chg_en, 0);
        tick(PC + 60);
        check("pulses", pulses - p0, 1);
        check("width", width >= PC && width <= PC + 1, 1);
        check("latched", st, ST_FAULT);
    endtask

    // watchdog start, reload, high-impedance disable
    task automatic t_wdog();
        int h;
        check("no start", wd_hits, 0);
        u_host.access();
        h = wd_hits;
        n = 0;
        while (wd_hits == h && n < 80) begin
            tick(1);
            n++;
        end
        check("wd time", n >= 46 && n <= 52, 1);
        u_host.access();
        h = wd_hits;
        repeat (6) begin
            tick(30);
            u_host.access();
        end
        check("reload", wd_hits, h);
        hiz = 1'b1;
        tick(1);
        u_host.access();
        tick(90);
        hiz = 1'b0;
        tick(90);
        check("hiz off", wd_hits, h);
        u_host.access();
        tick(55);
        check("hiz restart", wd_hits, h + 1);
    endtask

    // die temperature shutdown and hysteresis
    task automatic t_thermal();
        int p0;
        p0 = pulses;
        flags.die_shutdown = 1'b1;
        flags.die_below_hys = 1'b0;
        tick(3);
        check("th chg", {chg_en, mid_en, buck_en, aux_o}, 0);
        check("th err", err, ERR_THERMAL);
        flags.die_shutdown = 1'b0;
        tick(6);
        check("th hold", chg_en, 0);
        flags.die_below_hys = 1'b1;
        wait_st(ST_CHARGE, 10);
        check("resume", chg_en, 1);
        check("th pulse", pulses - p0, 1);
    endtask

    // thermistor zones
    task automatic t_zones();
        zone.cool = 1'b1;
        tick(3);
        check("cool", half_i, 1);
        zone.cool = 1'b0;
        zone.warm = 1'b1;
        vt = 13'h1000;
        tick(3);
        check("warm", vt_o, 13'h0F74);
        vt = 13'h0E42;
        tick(3);
        check("floor", vt_o, VT_FLOOR_MV);
        zone.warm = 1'b0;
        zone.hot = 1'b1;
        tick(3);
        check("hot", chg_en, 0);
        zone.ts_off = 1'b1;
        tick(3);
        check("ts off", chg_en, 1);
        zone = '0;
    endtask

    // status pins and chip disable
    task automatic t_status();
        int_en = 1'b1;
        tick(3);
        check("int chg", int_oe, 1);
        cd_n = 1'b1;
        tick(3);
        check("int off", int_oe, 0);
        check("rails", {chg_en, mid_en, buck_en}, 3'h3);
        cd_n = 1'b0;
        check("pg ok", pg_oe, 1);
        flags.vin_below_ovp = 1'b0;
        tick(3);
        check("pg ovp", pg_oe, 0);
        remap = 1'b1;
        btn = 1'b0;
        tick(3);
        check("pg btn", pg_oe, 1);
        btn = 1'b1;
        tick(3);
        check("pg rel", pg_oe, 0);
        sfault = 1'b1;
        tick(1);
        check("no int", int_oe, 0);
        sfault = 1'b0;
        vin = 1'b0;
        auxp = 1'b0;
        tick(3);
        check("batt rails", {mid_en, buck_en, aux_o}, 3'h7);
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        wd_hits = 0;
        arst_n = 1'b0;
        {vin, sdone, sfault, pre, term, rech} = 6'h34;
        {dsel, half_en, int_en, remap, hiz} = 6'h00;
        {cd_n, btn, auxp, aux_en} = 4'h7;
        vt = 13'h1000;
        flags = 8'hE8;
        zone = '0;
        tick(4);
        arst_n = 1'b1;
        check("rst", {st, int_oe, regs_def}, 0);
        t_fault(30);
        pre = 1'b0;
        t_fault(300);
        half_en = 1'b1;
        flags.loop_other = 1'b1;
        t_fault(600);
        half_en = 1'b0;
        flags.loop_other = 1'b0;
        dsel = 2'h3;
        cd_n = 1'b1;
        tick(3);
        cd_n = 1'b0;
        wait_st(ST_CHARGE, 10);
        t_wdog();
        t_thermal();
        t_zones();
        t_status();
        tally_and_finish();
    end

    // hang guard
    initial begin
        #(20000 * 5);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
